// ===== core/nsx_pkg.sv
/*
 * nsx_pkg: opcode patterns, field positions and widths for the
 * swap / direction-load / xor execute block.
 * assumes: 12-bit instruction words, 8-bit data path.
 */
package nsx_pkg;
    localparam int unsigned INSN_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned NIB_W  = 4;
    localparam int unsigned DEST_BIT = 5;
    localparam int unsigned DSEL_W = 3;

    // opcode matches: (insn & mask) == value
    localparam logic [11:0] SWAP_MASK  = 12'hfc0;
    localparam logic [11:0] SWAP_VAL   = 12'h380;
    localparam logic [11:0] XORF_MASK  = 12'hfc0;
    localparam logic [11:0] XORF_VAL   = 12'h180;
    localparam logic [11:0] XORL_MASK  = 12'hf00;
    localparam logic [11:0] XORL_VAL   = 12'hf00;
    localparam logic [11:0] DIRL_MASK  = 12'hff8;
    localparam logic [11:0] DIRL_VAL   = 12'h000;
    localparam logic [2:0]  DIRL_PORT  = 3'h6;

    localparam logic [7:0]  DATA_ZERO  = 8'h00;
    localparam logic [7:0]  DIR_RESET  = 8'hff;
    localparam logic [4:0]  ADDR_ZERO  = 5'h00;

    typedef enum logic [2:0] {
        NSX_OP_NONE,
        NSX_OP_SWAP,
        NSX_OP_DIRL,
        NSX_OP_XORL,
        NSX_OP_XORF
    } nsx_op_t;

    function automatic logic nsx_match(input logic [11:0] insn,
                                       input logic [11:0] mask,
                                       input logic [11:0] val);
        return (insn & mask) == val;
    endfunction
endpackage

// ===== core/nsx_decode.sv
/*
 * nsx_decode: combinational opcode classifier and field extraction.
 * assumes: instruction word is stable for the whole cycle it is valid.
 */
`timescale 1ns/1ps
`default_nettype none
module nsx_decode
    import nsx_pkg::*;
(
    input  wire logic [11:0] insn,
    output nsx_op_t          op,
    output logic             dest_file,
    output logic [4:0]       faddr,
    output logic [7:0]       literal,
    output logic [2:0]       dir_sel
);
    always_comb begin
        // direction load decodes for any f; only f == 6 loads, the rest still pulse done
        if (nsx_match(insn, SWAP_MASK, SWAP_VAL)) begin
            op = NSX_OP_SWAP;
        end else if (nsx_match(insn, XORF_MASK, XORF_VAL)) begin
            op = NSX_OP_XORF;
        end else if (nsx_match(insn, XORL_MASK, XORL_VAL)) begin
            op = NSX_OP_XORL;
        end else if (nsx_match(insn, DIRL_MASK, DIRL_VAL)) begin
            op = NSX_OP_DIRL;
        end else begin
            op = NSX_OP_NONE;
        end
    end

    assign dest_file = insn[DEST_BIT];
    assign faddr     = insn[ADDR_W-1:0];
    assign literal   = insn[DATA_W-1:0];
    assign dir_sel   = insn[DSEL_W-1:0];
endmodule
`default_nettype wire

// ===== core/nsx_exec.sv
/*
 * nsx_exec: single-cycle execute of nibble swap, direction load,
 * literal xor and file xor for an 8-bit core.
 * assumes: file register read data for INSN_ADDR is presented
 * combinationally with INSN; the core writes back FILE_WDATA when
 * FILE_WE pulses. W and the zero flag live here.
 */
// Contract
// - nibble swap yields file low nibble in high half and file high nibble in low half.
// - nibble swap decodes from 0011 10df ffff, bit 5 destination, bits 4:0 address.
// - nibble swap result goes to W when d is 0, back to the file register when d is 1.
// - nibble swap leaves every status flag unchanged.
// - direction load with address 6 copies W into the port direction register.
// - direction load decodes from nine zero upper bits and leaves flags unchanged.
// - literal xor combines W with the 8-bit literal into W, updating only zero.
// - file xor decodes from 0001 10df ffff and updates only the zero flag.
// - file xor result goes to W when d is 0, to the file register when d is 1.
`timescale 1ns/1ps
`default_nettype none
module nsx_exec
    import nsx_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        INSN_VALID,
    input  wire logic [11:0] INSN,
    input  wire logic [7:0]  FILE_RDATA,
    output logic [7:0]       W_REG,
    output logic             ZERO_FLAG,
    output logic [7:0]       DIR_REG,
    output logic             FILE_WE,
    output logic [4:0]       FILE_ADDR,
    output logic [7:0]       FILE_WDATA,
    output logic             DONE
);
    nsx_op_t    op;
    logic       dest_file;
    logic [4:0] faddr;
    logic [7:0] literal;
    logic [2:0] dir_sel;

    logic [7:0] w_r;
    logic       z_r;
    logic [7:0] dir_r;
    logic       fwe_r;
    logic [4:0] fadr_r;
    logic [7:0] fwd_r;
    logic       done_r;

    logic [7:0] result_nxt;
    logic       to_file_nxt;
    logic       upd_z_nxt;
    logic       exec;

    nsx_decode u_dec (
        .insn      (INSN),
        .op        (op),
        .dest_file (dest_file),
        .faddr     (faddr),
        .literal   (literal),
        .dir_sel   (dir_sel)
    );

    assign exec = INSN_VALID && (op != NSX_OP_NONE);

    always_comb begin
        result_nxt  = DATA_ZERO;
        to_file_nxt = 1'b0;
        upd_z_nxt   = 1'b0;
        unique case (op)
            NSX_OP_SWAP: begin
                result_nxt  = {FILE_RDATA[NIB_W-1:0], FILE_RDATA[DATA_W-1:NIB_W]};
                to_file_nxt = dest_file;
            end
            NSX_OP_XORF: begin
                result_nxt  = w_r ^ FILE_RDATA;
                to_file_nxt = dest_file;
                upd_z_nxt   = 1'b1;
            end
            NSX_OP_XORL: begin
                result_nxt = w_r ^ literal;
                upd_z_nxt  = 1'b1;
            end
            NSX_OP_DIRL: begin
                result_nxt = w_r;
            end
            NSX_OP_NONE: begin
                result_nxt = DATA_ZERO;
            end
        endcase
    end

    // W update: swap/xor with d=0 and literal xor
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            w_r <= DATA_ZERO;
        end else if (exec && op != NSX_OP_DIRL && !to_file_nxt) begin
            w_r <= result_nxt;
        end
    end

    // only the two xors touch the zero flag
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            z_r <= 1'b0;
        end else if (exec && upd_z_nxt) begin
            z_r <= (result_nxt == DATA_ZERO);
        end
    end

    // addresses other than 6 have no direction register on this part
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            dir_r <= DIR_RESET;
        end else if (exec && op == NSX_OP_DIRL && dir_sel == DIRL_PORT) begin
            dir_r <= w_r;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fwe_r  <= 1'b0;
            fadr_r <= ADDR_ZERO;
            fwd_r  <= DATA_ZERO;
        end else begin
            fwe_r <= exec && to_file_nxt;
            if (exec && to_file_nxt) begin
                fadr_r <= faddr;
                fwd_r  <= result_nxt;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            done_r <= 1'b0;
        end else begin
            done_r <= exec;
        end
    end

    assign W_REG      = w_r;
    assign ZERO_FLAG  = z_r;
    assign DIR_REG    = dir_r;
    assign FILE_WE    = fwe_r;
    assign FILE_ADDR  = fadr_r;
    assign FILE_WDATA = fwd_r;
    assign DONE       = done_r;

    sequence s_swap_issue;
        INSN_VALID && op == NSX_OP_SWAP;
    endsequence

    sequence s_xor_issue;
        INSN_VALID && (op == NSX_OP_XORL || op == NSX_OP_XORF);
    endsequence

    sequence s_xorf_issue;
        INSN_VALID && op == NSX_OP_XORF;
    endsequence

    // refused words and idle cycles must clear DONE and FILE_WE and leave every other register alone
    sequence s_idle_issue;
        !INSN_VALID || op == NSX_OP_NONE;
    endsequence

    a_swap_nibbles: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_swap_issue |=> ($past(dest_file) ? FILE_WDATA : W_REG)
            == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
        else $error("swap result nibbles wrong");

    a_swap_to_w: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (s_swap_issue and !dest_file) |=> !FILE_WE
            && W_REG == {$past(FILE_RDATA[NIB_W-1:0]), $past(FILE_RDATA[DATA_W-1:NIB_W])})
        else $error("swap to W misrouted");

    a_swap_decode: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN[11:6] == 6'h0e) |-> op == NSX_OP_SWAP)
        else $error("swap opcode not decoded");

    a_swap_dest: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (s_swap_issue and dest_file) |=> FILE_WE && W_REG == $past(W_REG))
        else $error("swap to file misrouted");

    a_swap_flags: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_swap_issue |=> $stable(ZERO_FLAG))
        else $error("swap changed zero flag");

    a_dir_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN_VALID && INSN == 12'h006) |=> DIR_REG == $past(W_REG))
        else $error("direction register not loaded");

    a_dir_other: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN_VALID && op == NSX_OP_DIRL && dir_sel != DIRL_PORT) |=> $stable(DIR_REG) && DONE)
        else $error("direction load to other address changed state");

    a_dir_flags: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN_VALID && op == NSX_OP_DIRL) |=> $stable(ZERO_FLAG) && $stable(W_REG))
        else $error("direction load disturbed flags");

    a_xorl_value: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN_VALID && op == NSX_OP_XORL) |=> W_REG == ($past(W_REG) ^ $past(INSN[7:0])))
        else $error("literal xor wrong");

    a_xorf_decode: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN[11:6] == 6'h06) |-> op == NSX_OP_XORF)
        else $error("file xor opcode not decoded");

    a_xorf_dest: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (INSN_VALID && op == NSX_OP_XORF && !dest_file) |=> !FILE_WE
            && W_REG == ($past(W_REG) ^ $past(FILE_RDATA)))
        else $error("file xor to W wrong");

    a_xorf_file: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (s_xorf_issue and dest_file) |=> FILE_WE && $stable(W_REG)
            && FILE_ADDR == $past(INSN[4:0])
            && FILE_WDATA == ($past(W_REG) ^ $past(FILE_RDATA)))
        else $error("file xor to file wrong");

    a_zero_flag: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_xor_issue |=> DONE && (ZERO_FLAG == (($past(W_REG)
            ^ ($past(op == NSX_OP_XORL) ? $past(INSN[7:0]) : $past(FILE_RDATA))) == DATA_ZERO)))
        else $error("zero flag mismatch");

    a_idle_quiet: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_idle_issue |=> !DONE && !FILE_WE && $stable(W_REG) && $stable(ZERO_FLAG))
        else $error("refused word changed state");
endmodule
`default_nettype wire

// ===== bench/nsx_exec_tb_top.sv
/* nsx_exec_tb_top: directed self-checking bench for the nibble swap,
   direction load and xor execute block.
   assumes: nsx_pkg and nsx_exec compiled first; one 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_tb_top
    import nsx_pkg::*;
;
    logic        ref_clk;
    logic        nrst;
    logic        insn_valid;
    logic [11:0] insn;
    logic [7:0]  file_rdata;
    logic [7:0]  w_reg;
    logic        zero_flag;
    logic [7:0]  dir_reg;
    logic        file_we;
    logic [4:0]  file_addr;
    logic [7:0]  file_wdata;
    logic        done;
    int          n_fail;
    int          checks;

    nsx_exec u_dut (.REF_CLK(ref_clk), .NRST(nrst), .INSN_VALID(insn_valid), .INSN(insn),
        .FILE_RDATA(file_rdata), .W_REG(w_reg), .ZERO_FLAG(zero_flag), .DIR_REG(dir_reg),
        .FILE_WE(file_we), .FILE_ADDR(file_addr), .FILE_WDATA(file_wdata), .DONE(done));

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // valid stays up so back-to-back calls need no release in between
    task automatic exec(input logic [11:0] i, input logic [7:0] rd);
        insn_valid = 1'b1;
        insn = i;
        file_rdata = rd;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic idle();
        insn_valid = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic outs(input logic [7:0] ew, input logic ez, input logic ewe, input logic ed);
        chk8("w_reg", ew, w_reg);
        chk1("zero_flag", ez, zero_flag);
        chk1("file_we", ewe, file_we);
        chk1("done", ed, done);
    endtask

    task automatic wr(input logic [7:0] ea, input logic [7:0] ed);
        chk8("file_addr", ea, {3'h0, file_addr});
        chk8("file_wdata", ed, file_wdata);
    endtask

    task automatic t_xor_lit();
        exec(12'hfb5, 8'h00);
        outs(8'hb5, 1'b0, 1'b0, 1'b1);
        exec(12'hfaf, 8'h00);
        outs(8'h1a, 1'b0, 1'b0, 1'b1);
        exec(12'hf1a, 8'h00);
        outs(8'h00, 1'b1, 1'b0, 1'b1);
        idle();
        chk1("done", 1'b0, done);
    endtask

    // zero flag is set on entry, so a swap that cleared it is caught
    task automatic t_swap();
        exec(12'h383, 8'ha5);
        outs(8'h5a, 1'b1, 1'b0, 1'b1);
        exec(12'h3bf, 8'h3c);
        outs(8'h5a, 1'b1, 1'b1, 1'b1);
        wr(8'h1f, 8'hc3);
        idle();
        chk1("file_we", 1'b0, file_we);
    endtask

    task automatic t_xor_file();
        exec(12'h1a0, 8'h5a);
        outs(8'h5a, 1'b1, 1'b1, 1'b1);
        wr(8'h00, 8'h00);
        exec(12'h184, 8'h0f);
        outs(8'h55, 1'b0, 1'b0, 1'b1);
        idle();
    endtask

    task automatic t_dir();
        exec(12'h006, 8'h00);
        outs(8'h55, 1'b0, 1'b0, 1'b1);
        chk8("dir_reg", 8'h55, dir_reg);
        exec(12'hf55, 8'h00);
        exec(12'h005, 8'h00);
        outs(8'h00, 1'b1, 1'b0, 1'b1);
        chk8("dir_reg", 8'h55, dir_reg);
        exec(12'h006, 8'h00);
        outs(8'h00, 1'b1, 1'b0, 1'b1);
        chk8("dir_reg", 8'h00, dir_reg);
    endtask

    task automatic t_refuse();
        exec(12'h00e, 8'h00);
        outs(8'h00, 1'b1, 1'b0, 1'b0);
        exec(12'h3c0, 8'h12);
        outs(8'h00, 1'b1, 1'b0, 1'b0);
        insn_valid = 1'b0;
        insn = 12'hf12;
        @(posedge ref_clk);
        #1;
        outs(8'h00, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_mid_reset();
        exec(12'hf77, 8'h00);
        outs(8'h77, 1'b0, 1'b0, 1'b1);
        nrst = 1'b0;
        insn_valid = 1'b0;
        #2;
        outs(DATA_ZERO, 1'b0, 1'b0, 1'b0);
        chk8("dir_reg", DIR_RESET, dir_reg);
        repeat (2) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        exec(12'hfa5, 8'h00);
        outs(8'ha5, 1'b0, 1'b0, 1'b1);
        idle();
    endtask

    initial begin
        nrst = 1'b0;
        insn_valid = 1'b0;
        insn = 12'h000;
        file_rdata = 8'h00;
        n_fail = 0;
        checks = 0;
        repeat (10) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        outs(DATA_ZERO, 1'b0, 1'b0, 1'b0);
        chk8("dir_reg", DIR_RESET, dir_reg);
        t_xor_lit();
        t_swap();
        t_xor_file();
        t_dir();
        t_refuse();
        t_mid_reset();
        end_sim();
    end

    // whole run is about 32 cycles; 1000 leaves ample margin
    initial begin
        #20000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
